//--- design/doeg_consts.svh
// constant definitions for the differential output enable gating block
`ifndef DOEG_CONSTS_SVH
`define DOEG_CONSTS_SVH

`define DOEG_NUM_OUTPUTS 12
`define DOEG_ENABLE_RESET 12'hFFF
`define DOEG_LAT_MIN_CLKS 4
`define DOEG_LAT_MAX_CLKS 12
`define DOEG_START_CLKS 4
`define DOEG_STOP_CLKS 6
`define DOEG_FS_133 1'h0
`define DOEG_FS_100 1'h1
`define DOEG_REG_ENABLE 4'h0
`define DOEG_REG_STATUS 4'h1
`define DOEG_REG_STRAP 4'h2
`define DOEG_REG_CONFIG 4'h3
`define DOEG_CFG_PUSH_PULL_BIT 0
`define DOEG_STS_PWRDN_BIT 12
`define DOEG_STS_PWRGD_SEEN_BIT 13

`endif

//--- design/doeg_pkg.sv
// types for the differential output enable gating block
package doeg_pkg;

	typedef enum logic [1:0] {
		DOEG_OFF,
		DOEG_STARTING,
		DOEG_RUN,
		DOEG_STOPPING
	} doeg_gate_state_t;

	typedef logic [3:0] doeg_addr_t;

endpackage : doeg_pkg

//--- design/doeg_out_gate.sv
// one glitch-free output gate with enable latency counting
`timescale 1ns/1ps
`default_nettype none
`include "doeg_consts.svh"

module doeg_out_gate
	import doeg_pkg::*;
#(
	parameter int unsigned START_CLKS = `DOEG_START_CLKS,
	parameter int unsigned STOP_CLKS = `DOEG_STOP_CLKS
) (
	input wire logic mclk_in,
	input wire logic rst_b_in,
	input wire logic want_in,
	input wire logic kill_in,
	output logic run_out
);

	// ----------------------------------------
	// latency counter and state
	// ----------------------------------------
	doeg_gate_state_t state_q;
	doeg_gate_state_t state_d;
	logic [3:0] cnt_q;
	logic [3:0] cnt_d;
	logic run_q;
	logic run_d;
	wire logic cnt_done = (cnt_q == 4'h1);

	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		run_d = run_q;
		if (kill_in) begin
			// power down overrides any pending latency
			state_d = DOEG_OFF;
			run_d = 1'b0;
			cnt_d = 4'h0;
		end else begin
			unique case (state_q)
				DOEG_OFF: begin
					if (want_in) begin
						state_d = DOEG_STARTING;
						cnt_d = 4'(START_CLKS);
					end
				end
				DOEG_STARTING: begin
					if (!want_in) begin
						state_d = DOEG_OFF;
					end else if (cnt_done) begin
						state_d = DOEG_RUN;
						run_d = 1'b1;
					end else begin
						cnt_d = cnt_q - 4'h1;
					end
				end
				DOEG_RUN: begin
					if (!want_in) begin
						// keep running long enough for four whole cycles
						state_d = DOEG_STOPPING;
						cnt_d = 4'(STOP_CLKS);
					end
				end
				DOEG_STOPPING: begin
					if (want_in) begin
						state_d = DOEG_RUN;
					end else if (cnt_done) begin
						state_d = DOEG_OFF;
						run_d = 1'b0;
					end else begin
						cnt_d = cnt_q - 4'h1;
					end
				end
			endcase
		end
	end

	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			state_q <= DOEG_OFF;
			cnt_q <= 4'h0;
			run_q <= 1'b0;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			run_q <= run_d;
		end
	end

	assign run_out = run_q;

endmodule : doeg_out_gate
`default_nettype wire

//--- design/doeg_top.sv
// top of the differential output enable gating block
// Overview of operation
// - one active-high enable bit per output, reset enabled
// - active-low enable pin per output, asynchronous
// - output runs only when bit 1, pin 0
// - disabled: hi-z, or driven low/low for push-pull
// - pin falling restarts output in 4..12 clocks
// - pin rising still gives at least 4 cycles
// - pin rising stops output within 12 clocks
// - output frequency equals input frequency, one-to-one; here the output runs at half of mclk_in
// - strap 0 selects 133 MHz, 1 selects 100
// - frequency change passes without runts or glitches
// - strap captured at power-good rising edge
// - power-down seen twice low disables outputs next falling
//
// Design decisions made here: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "doeg_consts.svh"

module doeg_top
	import doeg_pkg::*;
#(
	parameter int unsigned NUM_OUT = `DOEG_NUM_OUTPUTS
) (
	input wire logic mclk_in,
	input wire logic rst_b_in,
	input wire logic [3:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [31:0] reg_rdata_out,
	input wire logic [NUM_OUT-1:0] out_enable_n_in,
	input wire logic power_good_down_n_in,
	input wire logic freq_select_strap_in,
	output logic [NUM_OUT-1:0] diff_clock_out,
	output logic [NUM_OUT-1:0] diff_clock_out_inverted,
	output logic [NUM_OUT-1:0] diff_clock_oe_out,
	output logic feedback_clock_out,
	output logic feedback_clock_inv_out,
	output logic feedback_clock_oe_out,
	output logic pll_on_out,
	output logic freq_select_out
);

	// ----------------------------------------
	// synchronisers
	// ----------------------------------------
	// pins are asynchronous, so both edges go through two flops first
	logic [NUM_OUT-1:0] oe_meta_q;
	logic [NUM_OUT-1:0] oe_sync_q;
	logic pg_meta_q;
	logic pg_sync_q;
	logic pg_prev_q;

	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			oe_meta_q <= '1;
			oe_sync_q <= '1;
			pg_meta_q <= 1'b0;
			pg_sync_q <= 1'b0;
			pg_prev_q <= 1'b0;
		end else begin
			oe_meta_q <= out_enable_n_in;
			oe_sync_q <= oe_meta_q;
			pg_meta_q <= power_good_down_n_in;
			pg_sync_q <= pg_meta_q;
			pg_prev_q <= pg_sync_q;
		end
	end

	wire logic pg_rise = pg_sync_q & ~pg_prev_q;

	// ----------------------------------------
	// registers
	// ----------------------------------------
	logic [NUM_OUT-1:0] enable_q;
	logic push_pull_q;
	logic fs_q;
	logic pg_seen_q;
	logic [1:0] pd_cnt_q;
	logic [31:0] rdata_q;

	wire logic wr_enable = reg_wr_in & (reg_addr_in == `DOEG_REG_ENABLE);
	wire logic wr_config = reg_wr_in & (reg_addr_in == `DOEG_REG_CONFIG);

	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			enable_q <= NUM_OUT'(`DOEG_ENABLE_RESET);
			push_pull_q <= 1'b0;
		end else begin
			if (wr_enable) begin
				enable_q <= reg_wdata_in[NUM_OUT-1:0];
			end
			if (wr_config) begin
				push_pull_q <= reg_wdata_in[`DOEG_CFG_PUSH_PULL_BIT];
			end
		end
	end

	// strap latched on power good rising, never at reset release
	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			fs_q <= `DOEG_FS_100;
			pg_seen_q <= 1'b0;
		end else if (pg_rise) begin
			fs_q <= freq_select_strap_in;
			pg_seen_q <= 1'b1;
		end
	end

	// ----------------------------------------
	// power down qualification
	// ----------------------------------------
	// two sampled lows in a row before acting, which filters runts
	logic run_phase_q;
	wire logic pd_low = ~pg_sync_q;

	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			pd_cnt_q <= 2'h2;
		end else if (!pd_low) begin
			pd_cnt_q <= 2'h0;
		end else if (pd_cnt_q != 2'h2) begin
			pd_cnt_q <= pd_cnt_q + 2'h1;
		end
	end

	wire logic pd_active = (pd_cnt_q == 2'h2);

	// ----------------------------------------
	// output clock and gates
	// ----------------------------------------
	// output toggles once per system clock, so it runs at half the mclk_in rate
	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			run_phase_q <= 1'b0;
		end else begin
			run_phase_q <= ~run_phase_q;
		end
	end

	logic [NUM_OUT-1:0] run_w;
	wire logic [NUM_OUT-1:0] want_w = enable_q & ~oe_sync_q;

	genvar gi;
	generate
		for (gi = 0; gi < NUM_OUT; gi++) begin : g_out
			doeg_out_gate #(
				.START_CLKS(`DOEG_START_CLKS),
				.STOP_CLKS(`DOEG_STOP_CLKS)
			) u_gate (
				.mclk_in(mclk_in),
				.rst_b_in(rst_b_in),
				.want_in(want_w[gi]),
				.kill_in(pd_active),
				.run_out(run_w[gi])
			);
		end
	endgenerate

	// gating changes only land while the clock leg is low, so no runt
	logic [NUM_OUT-1:0] gate_q;
	logic [NUM_OUT-1:0] dif_q;
	logic [NUM_OUT-1:0] difn_q;
	logic [NUM_OUT-1:0] oe_q;
	logic fb_q;
	logic fbn_q;
	logic fb_oe_q;

	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			gate_q <= '0;
		end else if (run_phase_q) begin
			gate_q <= run_w;
		end
	end

	wire logic [NUM_OUT-1:0] drive_w = gate_q | {NUM_OUT{push_pull_q}};

	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			dif_q <= '0;
			difn_q <= '0;
			oe_q <= '0;
			fb_q <= 1'b0;
			fbn_q <= 1'b0;
			fb_oe_q <= 1'b0;
		end else begin
			dif_q <= gate_q & {NUM_OUT{~run_phase_q}};
			difn_q <= gate_q & {NUM_OUT{run_phase_q}};
			oe_q <= drive_w;
			fb_q <= ~pd_active & ~run_phase_q;
			fbn_q <= ~pd_active & run_phase_q;
			fb_oe_q <= ~pd_active | push_pull_q;
		end
	end

	// ----------------------------------------
	// read port
	// ----------------------------------------
	wire logic [31:0] status_w = {18'h0, pg_seen_q, pd_active, run_w};

	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rdata_q <= 32'h0;
		end else if (reg_rd_in) begin
			unique case (reg_addr_in)
				`DOEG_REG_ENABLE: rdata_q <= 32'(enable_q);
				`DOEG_REG_STATUS: rdata_q <= status_w;
				`DOEG_REG_STRAP: rdata_q <= {31'h0, fs_q};
				`DOEG_REG_CONFIG: rdata_q <= {31'h0, push_pull_q};
				default: rdata_q <= 32'h0;
			endcase
		end else begin
			rdata_q <= 32'h0;
		end
	end

	assign reg_rdata_out = rdata_q;
	assign diff_clock_out = dif_q;
	assign diff_clock_out_inverted = difn_q;
	assign diff_clock_oe_out = oe_q;
	assign feedback_clock_out = fb_q;
	assign feedback_clock_inv_out = fbn_q;
	assign feedback_clock_oe_out = fb_oe_q;
	assign pll_on_out = ~pd_active;
	assign freq_select_out = fs_q;

endmodule : doeg_top
`default_nettype wire

//--- verification/doeg_far_side.sv
// clock receivers and strap resistor beyond the output pins
`timescale 1ns/1ps
`default_nettype none
module doeg_far_side (
	input wire logic mclk_in,
	input wire logic strap_high_in,
	input wire logic [11:0] leg_p_in,
	input wire logic [11:0] leg_n_in,
	output logic freq_select_strap_out,
	output logic [11:0] live_out = 12'h000
);
	// ----
	// receivers
	// ----
	logic [11:0] prev_q = 12'h000;
	// a pull resistor, so the level only moves when the bench swaps it
	assign freq_select_strap_out = strap_high_in;
	// live only on a true swing that moved since the last edge
	always_ff @(posedge mclk_in) begin
		prev_q <= leg_p_in;
		live_out <= (leg_p_in ^ prev_q) & (leg_p_in ^ leg_n_in);
	end
endmodule : doeg_far_side
`default_nettype wire

//--- verification/doeg_chk.sv
// assertions on the ports of the gating top
`timescale 1ns/1ps
`default_nettype none
module doeg_chk #(parameter int unsigned NUM_OUT = 12) (
	input wire logic mclk_in,
	input wire logic rst_b_in,
	input wire logic [NUM_OUT-1:0] out_enable_n_in,
	input wire logic power_good_down_n_in,
	input wire logic freq_select_strap_in,
	input wire logic [NUM_OUT-1:0] diff_clock_out,
	input wire logic [NUM_OUT-1:0] diff_clock_out_inverted,
	input wire logic feedback_clock_out,
	input wire logic pll_on_out,
	input wire logic freq_select_out
);
	// ----
	// output 0 stands for all gates
	// ----
	wire logic off0 = !(diff_clock_out[0] || diff_clock_out_inverted[0]);
	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (!rst_b_in);
	a_legs_exclusive: assert property ((diff_clock_out & diff_clock_out_inverted) == '0)
		else $error("both legs high");
	a_start_window: assert property ($fell(out_enable_n_in[0]) && off0 && pll_on_out |-> off0 [*8] ##[1:16] !off0)
		else $error("start outside window");
	a_stop_bound: assert property ($rose(out_enable_n_in[0]) |-> ##[1:24] off0)
		else $error("stop too late");
	a_stop_min_cycles: assert property ($rose(out_enable_n_in[0]) && !off0 |->
		(diff_clock_out[0] != $past(diff_clock_out[0])) [*8]) else $error("stopped too early");
	a_run_toggles: assert property (!off0 && !$past(off0) |-> diff_clock_out[0] != $past(diff_clock_out[0]))
		else $error("running leg held");
	// the last half period on the inverted leg may still be in flight after the eighth low sample
	a_power_off: assert property (!power_good_down_n_in [*8] |-> ##2 (diff_clock_out == '0 &&
		diff_clock_out_inverted == '0 && !feedback_clock_out && !pll_on_out)) else $error("not powered down");
	a_fb_running: assert property (pll_on_out [*3] |-> feedback_clock_out != $past(feedback_clock_out))
		else $error("feedback stalled");
	a_strap_capture: assert property ($rose(pll_on_out) |=> freq_select_out == freq_select_strap_in)
		else $error("strap not captured");
	a_strap_held: assert property (pll_on_out && $past(pll_on_out) |=> $stable(freq_select_out))
		else $error("strap followed pin");
endmodule : doeg_chk
bind doeg_top doeg_chk #(.NUM_OUT(NUM_OUT)) doeg_chk_inst (.mclk_in(mclk_in), .rst_b_in(rst_b_in),
	.out_enable_n_in(out_enable_n_in), .power_good_down_n_in(power_good_down_n_in),
	.freq_select_strap_in(freq_select_strap_in), .diff_clock_out(diff_clock_out),
	.diff_clock_out_inverted(diff_clock_out_inverted), .feedback_clock_out(feedback_clock_out),
	.pll_on_out(pll_on_out), .freq_select_out(freq_select_out));
`default_nettype wire

//--- verification/doeg_top_tb.sv
// self-checking bench for the gating block
`timescale 1ns/1ps
`default_nettype none
`include "doeg_consts.svh"
module doeg_top_tb;
	// ----
	// design and far side
	// ----
	logic clk = 1'h0;
	logic rst_b = 1'h0;
	logic wr = 1'h0;
	logic rd_s = 1'h0;
	logic pg = 1'h0;
	logic strap_hi = 1'h0;
	logic [3:0] addr = 4'h0;
	logic [31:0] wdata = 32'h0;
	logic [11:0] oen = 12'hFFF;
	wire logic [31:0] rdata;
	wire logic [11:0] p, n, oe, live;
	wire logic fb, fbn, fboe, pll, fs, strap;
	int failures = 0;
	int checks_done = 0;
	doeg_top doeg_top_inst (.mclk_in(clk), .rst_b_in(rst_b), .reg_addr_in(addr), .reg_wdata_in(wdata),
		.reg_wr_in(wr), .reg_rd_in(rd_s), .reg_rdata_out(rdata), .out_enable_n_in(oen),
		.power_good_down_n_in(pg), .freq_select_strap_in(strap), .diff_clock_out(p),
		.diff_clock_out_inverted(n), .diff_clock_oe_out(oe), .feedback_clock_out(fb),
		.feedback_clock_inv_out(fbn), .feedback_clock_oe_out(fboe), .pll_on_out(pll), .freq_select_out(fs));
	doeg_far_side doeg_far_side_inst (.mclk_in(clk), .strap_high_in(strap_hi), .leg_p_in(p), .leg_n_in(n),
		.freq_select_strap_out(strap), .live_out(live));
	initial begin
		forever #25 clk = ~clk;
	end
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch %s expected %0h seen %0h", what, exp, seen);
		end
	endtask : chk
	task automatic cyc(input int c);
		repeat (c) @(posedge clk);
	endtask : cyc
	task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		wr <= 1'h1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'h0;
	endtask : wr_reg
	task automatic rd_reg(input logic [3:0] a, input logic [31:0] exp, input string what);
		@(posedge clk);
		rd_s <= 1'h1;
		addr <= a;
		@(posedge clk);
		rd_s <= 1'h0;
		#1;
		chk(what, rdata, exp);
	endtask : rd_reg
	// bounded wait for the receiver to see the wanted state
	task automatic lat(input int i, input logic want, output int c);
		c = 0;
		while (live[i] !== want && c < 40) begin
			@(posedge clk);
			#1;
			c++;
		end
	endtask : lat
	task automatic summarize();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : summarize
	// ----
	// scenarios
	// ----
	task automatic t_power_up();
		@(posedge clk);
		pg <= 1'h1;
		cyc(8);
		#1;
		chk("pll on", pll, 1'h1);
		chk("fb oe", fboe, 1'h1);
		chk("fs 133", fs, `DOEG_FS_133);
		chk("idle", {p, n}, 24'h0);
		rd_reg(`DOEG_REG_ENABLE, 32'hFFF, "enable");
		rd_reg(4'hF, 32'h0, "unmapped");
		@(posedge clk);
		strap_hi <= 1'h1;
		cyc(6);
		#1;
		chk("fs held", fs, `DOEG_FS_133);
	endtask : t_power_up
	task automatic t_pin_cycle();
		int c;
		int k;
		@(posedge clk);
		oen[0] <= 1'h0;
		#1;
		lat(0, 1'h1, c);
		chk("start", c >= 8 && c <= 25, 1'h1);
		chk("neighbour", live[1], 1'h0);
		k = 0;
		repeat (20) begin
			@(posedge clk);
			#1;
			k += live[0];
		end
		chk("rate", k, 20);
		rd_reg(`DOEG_REG_STATUS, (32'h1 << `DOEG_STS_PWRGD_SEEN_BIT) | 32'h1, "status run");
		@(posedge clk);
		oen[0] <= 1'h1;
		#1;
		lat(0, 1'h0, c);
		chk("stop", c >= 8 && c <= 25, 1'h1);
	endtask : t_pin_cycle
	task automatic t_reg_gate();
		int c;
		@(posedge clk);
		oen[1] <= 1'h0;
		#1;
		lat(1, 1'h1, c);
		wr_reg(`DOEG_REG_ENABLE, 32'hFFD);
		cyc(26);
		#1;
		chk("reg off", {p[1], n[1], oe[1], live[1]}, 4'h0);
		wr_reg(`DOEG_REG_CONFIG, 32'h1);
		cyc(2);
		#1;
		chk("push pull", {p[1], n[1], oe[1]}, 3'h1);
		rd_reg(`DOEG_REG_CONFIG, 32'h1, "config");
		wr_reg(`DOEG_REG_ENABLE, 32'hFFF);
		lat(1, 1'h1, c);
		chk("reg on", c < 30, 1'h1);
	endtask : t_reg_gate
	task automatic t_power_down();
		int c;
		@(posedge clk);
		pg <= 1'h0;
		cyc(12);
		#1;
		chk("pd legs", {p, n, fb, fbn, pll}, 27'h0);
		chk("pd oe", oe, 12'hFFF);
		chk("pd fb oe", fboe, 1'h1);
		rd_reg(`DOEG_REG_STATUS, (32'h1 << `DOEG_STS_PWRDN_BIT) | (32'h1 << `DOEG_STS_PWRGD_SEEN_BIT), "status pd");
		@(posedge clk);
		pg <= 1'h1;
		cyc(8);
		#1;
		chk("fs 100", fs, `DOEG_FS_100);
		rd_reg(`DOEG_REG_STRAP, 32'h1, "strap");
		lat(1, 1'h1, c);
		chk("resume", live[1], 1'h1);
	endtask : t_power_down
	initial begin
		cyc(2);
		rst_b <= 1'h1;
		t_power_up();
		t_pin_cycle();
		t_reg_gate();
		t_power_down();
		summarize();
	end
	// whole run is under two hundred cycles
	initial begin
		cyc(2000);
		failures++;
		summarize();
	end
endmodule : doeg_top_tb
`default_nettype wire
